//--- rtl/wake_status_irq_logic.sv
// Purpose: wake sequencing, event status register and interrupt line
// Assumes: serial decoder gives one-cycle read and command pulses on REF_CLK
// Notes: comparator and pin inputs are synchronised; control bits are not
module wake_status_irq_logic import wake_status_pkg::*; #(
    parameter int DEBOUNCE_TICKS = DEBOUNCE_TICKS_DEF,
    parameter int DCLK_DIV = DCLK_DIV_DEF
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [KEY_COUNT-1:0] KEY_INPUT_N,
    input wire logic BUTTON_WAKE_PIN,
    input wire logic AUX_LOW_CMP,
    input wire logic AUX_HIGH_CMP,
    input wire logic AUX_ABOVE_SUPPLY_CMP,
    input wire logic EXT_SUPPLY_LOW_CMP,
    input wire logic EXT_SUPPLY_RECOVERED_CMP,
    input wire logic EXT_SUPPLY_CLK_OK_CMP,
    input wire logic EXT_SUPPLY_GOOD_CMP,
    input wire logic CORE_SUPPLY_UP_CMP,
    input wire logic OSC_SETTLED,
    input wire logic STATUS_READ,
    input wire logic CLEAR_IRQ_CMD,
    input wire logic OFF_CMD,
    input wire logic EXT_SUPPLY_ENABLE_SW,
    input wire logic CLK_ON_SW,
    output logic [7:0] STATUS_DATA,
    output logic IRQ,
    output logic HOST_RESET_N,
    output logic CORE_SUPPLY_EN,
    output logic EXT_SUPPLY_ENABLE_BIT,
    output logic CLK_ON_BIT,
    output logic CLK_OUT_EN,
    output logic OFF_MODE
);

    if (MIN_WAKE_CYCLES < 1 || MIN_WAKE_CYCLES > 255) begin : g_check
        $error("wake_status_irq_logic: minimum wake time does not fit its counter");
    end

    // ==========================================================
    // input synchronisation
    localparam int SYNC_W = KEY_COUNT + 10;

    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic [KEY_COUNT-1:0] keys_n;
    logic button;
    logic aux_low;
    logic aux_high;
    logic aux_above;
    logic supply_low;
    logic supply_recovered;
    logic supply_clk_ok;
    logic supply_good;
    logic core_up;
    logic osc_ok;

    // gather every pin and comparator into one synchroniser
    assign pins_async = {OSC_SETTLED, CORE_SUPPLY_UP_CMP, EXT_SUPPLY_GOOD_CMP,
                         EXT_SUPPLY_CLK_OK_CMP, EXT_SUPPLY_RECOVERED_CMP, EXT_SUPPLY_LOW_CMP,
                         AUX_ABOVE_SUPPLY_CMP, AUX_HIGH_CMP, AUX_LOW_CMP, BUTTON_WAKE_PIN,
                         KEY_INPUT_N};

    pin_sync #(
        .WIDTH(SYNC_W),
        .INIT({10'h000, KEY_IDLE})
    ) u_sync (
        .clk(REF_CLK),
        .rst(RST),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    // split the synchronised bundle back into named levels
    assign keys_n = pins_sync[KEY_COUNT-1:0];
    assign button = pins_sync[KEY_COUNT];
    assign aux_low = pins_sync[KEY_COUNT+1];
    assign aux_high = pins_sync[KEY_COUNT+2];
    assign aux_above = pins_sync[KEY_COUNT+3];
    assign supply_low = pins_sync[KEY_COUNT+4];
    assign supply_recovered = pins_sync[KEY_COUNT+5];
    assign supply_clk_ok = pins_sync[KEY_COUNT+6];
    assign supply_good = pins_sync[KEY_COUNT+7];
    assign core_up = pins_sync[KEY_COUNT+8];
    assign osc_ok = pins_sync[KEY_COUNT+9];

    // ==========================================================
    // power mode sequencing
    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAKING,
        ST_ACTIVE
    } power_e;

    typedef enum logic [1:0] {
        CAUSE_NONE,
        CAUSE_KEY,
        CAUSE_BUTTON,
        CAUSE_AUX
    } cause_e;

    power_e state_reg, state_next;
    cause_e cause_reg, cause_next;
    logic [KEY_COUNT-1:0] wake_key_reg, wake_key_next;
    logic [WAKE_CNT_W-1:0] hold_reg, hold_next;
    logic armed_reg, armed_next;
    logic woke;
    logic hold_cond;
    logic active;

    // off mode wakes at once on aux low; keys and button need an edge, then a held level
    always_comb begin
        state_next = state_reg;
        cause_next = cause_reg;
        wake_key_next = wake_key_reg;
        hold_next = hold_reg;
        armed_next = armed_reg;
        woke = 1'b0;
        hold_cond = (keys_n != KEY_IDLE) || button;
        case (state_reg)
            ST_OFF: begin
                // edge needed: arm only once every key is high and button low
                if (!hold_cond) begin
                    armed_next = 1'b1;
                    hold_next = '0;
                end else if (armed_reg) begin
                    hold_next = hold_reg + 1'b1;
                end
                if (aux_low) begin
                    state_next = ST_WAKING;
                    cause_next = CAUSE_AUX;
                end else if (armed_reg && hold_cond && hold_reg == WAKE_CNT_W'(MIN_WAKE_CYCLES - 1)) begin
                    state_next = ST_WAKING;
                    cause_next = button ? CAUSE_BUTTON : CAUSE_KEY;
                    wake_key_next = ~keys_n;
                end
            end
            ST_WAKING: begin
                // digital logic comes alive once core supply and oscillator are up
                if (core_up && osc_ok) begin
                    state_next = ST_ACTIVE;
                    woke = 1'b1;
                end
            end
            ST_ACTIVE: begin
                // only the off command leaves; the button level never does
                if (OFF_CMD) begin
                    state_next = ST_OFF;
                    armed_next = 1'b0;
                    hold_next = '0;
                    cause_next = CAUSE_NONE;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    // register the mode state; reset lands in the active mode
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_reg <= ST_ACTIVE;
            cause_reg <= CAUSE_NONE;
            wake_key_reg <= 5'h00;
            hold_reg <= '0;
            armed_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cause_reg <= cause_next;
            wake_key_reg <= wake_key_next;
            hold_reg <= hold_next;
            armed_reg <= armed_next;
        end
    end

    assign active = (state_reg == ST_ACTIVE);

    // ==========================================================
    // key debounce
    logic deb_running;
    logic deb_done;

    key_debounce #(
        .TICKS(DEBOUNCE_TICKS),
        .DIV(DCLK_DIV)
    ) u_debounce (
        .clk(REF_CLK),
        .rst(RST),
        .enable(active),
        .keys_n(keys_n),
        .running(deb_running),
        .done(deb_done)
    );

    // ==========================================================
    // status flags and interrupt causes
    logic [KEY_COUNT-1:0] key_status_reg, key_status_next;
    logic wake_flag_reg, wake_flag_next;
    logic low_flag_reg, low_flag_next;
    logic aux_flag_reg, aux_flag_next;
    logic low_read_reg, low_read_next;
    logic key_pend_reg, key_pend_next;
    logic wake_pend_reg, wake_pend_next;
    logic aux_pend_reg, aux_pend_next;
    logic button_prev_reg, aux_prev_reg;
    logic button_rise, aux_rise;
    logic wake_set, aux_set;

    // clears first, sets last, so an event in the read cycle survives
    always_comb begin
        button_rise = button && !button_prev_reg;
        aux_rise = aux_high && !aux_prev_reg;
        wake_set = (active && button_rise) || (woke && cause_reg == CAUSE_BUTTON);
        aux_set = (active && aux_rise && aux_above)
                  || (woke && cause_reg == CAUSE_AUX && aux_high);
        key_status_next = key_status_reg;
        wake_flag_next = wake_flag_reg;
        aux_flag_next = aux_flag_reg;
        low_flag_next = low_flag_reg;
        low_read_next = low_read_reg;
        key_pend_next = key_pend_reg;
        wake_pend_next = wake_pend_reg;
        aux_pend_next = aux_pend_reg;
        if (STATUS_READ) begin
            wake_flag_next = 1'b0;
            aux_flag_next = 1'b0;
            key_pend_next = 1'b0;
            wake_pend_next = 1'b0;
            aux_pend_next = 1'b0;
            low_read_next = low_flag_reg;
        end
        if (CLEAR_IRQ_CMD) begin
            key_pend_next = 1'b0;
            wake_pend_next = 1'b0;
            aux_pend_next = 1'b0;
        end
        // low supply needs both a read and recovery before it drops
        if (low_read_next && supply_recovered) begin
            low_flag_next = 1'b0;
            low_read_next = 1'b0;
        end
        if (supply_low) begin
            low_flag_next = 1'b1;
            low_read_next = 1'b0;
        end
        if (deb_done) begin
            key_status_next = ~keys_n;
            key_pend_next = 1'b1;
        end
        if (woke && cause_reg == CAUSE_KEY) begin
            key_status_next = key_status_reg | wake_key_reg;
            key_pend_next = 1'b1;
        end
        if (wake_set) begin
            wake_flag_next = 1'b1;
            if (!wake_flag_reg || STATUS_READ) begin
                wake_pend_next = 1'b1;
            end
        end
        if (aux_set) begin
            aux_flag_next = 1'b1;
            if (!aux_flag_reg || STATUS_READ) begin
                aux_pend_next = 1'b1;
            end
        end
    end

    // register status flags and pending causes
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            key_status_reg <= 5'h00;
            wake_flag_reg <= 1'b0;
            low_flag_reg <= 1'b0;
            aux_flag_reg <= 1'b0;
            low_read_reg <= 1'b0;
            key_pend_reg <= 1'b0;
            wake_pend_reg <= 1'b0;
            aux_pend_reg <= 1'b0;
            button_prev_reg <= 1'b0;
            aux_prev_reg <= 1'b0;
        end else begin
            key_status_reg <= key_status_next;
            wake_flag_reg <= wake_flag_next;
            low_flag_reg <= low_flag_next;
            aux_flag_reg <= aux_flag_next;
            low_read_reg <= low_read_next;
            key_pend_reg <= key_pend_next;
            wake_pend_reg <= wake_pend_next;
            aux_pend_reg <= aux_pend_next;
            button_prev_reg <= button;
            aux_prev_reg <= aux_high;
        end
    end

    // ==========================================================
    // outputs, all straight from flip-flops
    logic [7:0] status_next;
    logic irq_next;
    logic reset_n_next;
    logic core_en_next;
    logic ext_en_next;
    logic clk_on_next;
    logic clk_out_next;
    logic off_next;

    // wake flag and mode terms follow the next state without lag; the debounce term uses the registered deb_running
    always_comb begin
        status_next = STATUS_RESET;
        status_next[KEY_STATUS_LSB +: KEY_COUNT] = key_status_next;
        status_next[WAKE_FLAG_BIT] = wake_flag_next;
        status_next[LOW_SUPPLY_BIT] = low_flag_next;
        status_next[AUX_FLAG_BIT] = aux_flag_next;
        irq_next = key_pend_next || wake_pend_next || aux_pend_next;
        reset_n_next = (state_next != ST_OFF) && (state_next != ST_WAKING || woke)
                       && supply_good && osc_ok;
        core_en_next = (state_next != ST_OFF);
        ext_en_next = EXT_SUPPLY_ENABLE_SW || deb_running
                      || wake_flag_next
                      || state_next == ST_WAKING;
        clk_on_next = CLK_ON_SW || deb_running || wake_flag_next;
        // gated asynchronously downstream, so the first clock may be short
        clk_out_next = clk_on_next && supply_clk_ok && osc_ok && state_next != ST_OFF;
        off_next = (state_next == ST_OFF);
    end

    // output flip-flops
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            STATUS_DATA <= STATUS_RESET;
            IRQ <= 1'b0;
            HOST_RESET_N <= 1'b0;
            CORE_SUPPLY_EN <= 1'b0;
            EXT_SUPPLY_ENABLE_BIT <= 1'b0;
            CLK_ON_BIT <= 1'b0;
            CLK_OUT_EN <= 1'b0;
            OFF_MODE <= 1'b0;
        end else begin
            STATUS_DATA <= status_next;
            IRQ <= irq_next;
            HOST_RESET_N <= reset_n_next;
            CORE_SUPPLY_EN <= core_en_next;
            EXT_SUPPLY_ENABLE_BIT <= ext_en_next;
            CLK_ON_BIT <= clk_on_next;
            CLK_OUT_EN <= clk_out_next;
            OFF_MODE <= off_next;
        end
    end

endmodule

//--- pkg/wake_status_pkg.sv
// Purpose: shared constants for the wake, status and interrupt logic
// Assumes: REF_CLK at 100 MHz, synchronous active-high reset
// Notes: register map and wake timing
//
// Behaviour
// - key status bits read inverted: low key pin gives 1, high gives 0
// - active mode: key event clears and starts debounce; at 8195 ticks update, interrupt, stop
// - second event on same key before terminal count stops counter, no update
// - event on another key before terminal count clears and restarts counter
// - while debounce runs, external supply and clock-output enables forced to 1
// - pending key interrupt cleared by status read or clear-interrupt command
// - OFF: key low for minimum wake time drives host reset low, enables supplies
// - after key wake, core up and oscillator settled: set matching key bit, interrupt
// - host reset released only with external supply good and oscillator settled
// - clock output starts after supply above threshold and oscillator settled
// - OFF: button high for minimum time wakes; later sets wake flag with interrupt
// - active: button rising edge sets wake flag; interrupt only on 0 to 1
// - status read clears wake flag and its interrupt
// - while wake flag is 1, supply and clock-output enables held at 1
// - button low never enters OFF; unused button pin tied to ground by board
// - low-supply bit set when external supply falls below low threshold
// - low-supply bit cleared only after recovery and a status read
// - OFF: aux above lower threshold wakes; above upper sets aux flag, interrupt
// - active: aux rising edge above first supply margin sets aux flag, interrupt on 0 to 1
// - status read clears aux flag and its interrupt
// - eight status bits in one register at address 8
// - interrupt raised on wake flag, aux flag or key status event
// - clear-interrupt command drives interrupt output low
package wake_status_pkg;

    // ==========================================================
    // status register map
    localparam int KEY_COUNT = 5;
    localparam logic [4:0] STATUS_ADDR = 5'h08;
    localparam int KEY_STATUS_LSB = 0;
    localparam int WAKE_FLAG_BIT = 5;
    localparam int LOW_SUPPLY_BIT = 6;
    localparam int AUX_FLAG_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [4:0] KEY_IDLE = 5'h1f;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEBOUNCE_TICKS_DEF = 8195;
    localparam int DCLK_DIV_DEF = 4;
    localparam int MIN_WAKE_NS = 1000;
    localparam int MIN_WAKE_CYCLES = (MIN_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 8;

endpackage

//--- rtl/pin_sync.sv
// Purpose: two-stage synchroniser for pins and comparator outputs
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second stage
module pin_sync import wake_status_pkg::*; #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;

    // next values of both stages
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // register stages, reset to the idle pin level
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= INIT;
            sync_out <= INIT;
        end else begin
            meta_reg <= meta_next;
            sync_out <= sync_next;
        end
    end

endmodule

//--- rtl/key_debounce.sv
// Purpose: shared debounce counter for the five key inputs
// Assumes: keys already synchronised, active low
// Notes: counts slow ticks from an internal divider of the clock
module key_debounce import wake_status_pkg::*; #(
    parameter int TICKS = DEBOUNCE_TICKS_DEF,
    parameter int DIV = DCLK_DIV_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [KEY_COUNT-1:0] keys_n,
    output logic running,
    output logic done
);

    if (TICKS < 2 || TICKS > 16383 || DIV < 1 || DIV > 255) begin : g_check
        $error("key_debounce: TICKS or DIV out of range");
    end

    logic [7:0] div_reg, div_next;
    logic [13:0] cnt_reg, cnt_next;
    logic [KEY_COUNT-1:0] prev_reg, prev_next, last_reg, last_next;
    logic run_next, done_next, tick;
    logic [KEY_COUNT-1:0] ev;

    // any change on a key pin is an event; edges tracked even when idle
    always_comb begin
        tick = (div_reg == 8'(DIV - 1));
        div_next = tick ? 8'h00 : div_reg + 8'h01;
        ev = keys_n ^ prev_reg;
        prev_next = keys_n;
        cnt_next = cnt_reg;
        run_next = running;
        last_next = last_reg;
        done_next = 1'b0;
        if (!enable) begin
            run_next = 1'b0;
        end else if (ev != 5'h00) begin
            if (running && ev == last_reg) begin
                run_next = 1'b0;
            end else begin
                run_next = 1'b1;
                cnt_next = 14'h0000;
                last_next = ev;
            end
        end else if (running && tick) begin
            if (cnt_reg == 14'(TICKS - 1)) begin
                run_next = 1'b0;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 14'h0001;
            end
        end
    end

    // register the counter state
    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg <= 8'h00;
            cnt_reg <= 14'h0000;
            prev_reg <= KEY_IDLE;
            last_reg <= 5'h00;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            div_reg <= div_next;
            cnt_reg <= cnt_next;
            prev_reg <= prev_next;
            last_reg <= last_next;
            running <= run_next;
            done <= done_next;
        end
    end

endmodule

//--- tb/wake_status_sva.sv
// Purpose: port checks for the wake, status and interrupt block
// Assumes: one clock, synchronous active-high reset
// Notes: quiet means no wake pin moved for a whole debounce span
module wake_status_sva import wake_status_pkg::*; #(
    parameter int DEBOUNCE_TICKS = DEBOUNCE_TICKS_DEF,
    parameter int DCLK_DIV = DCLK_DIV_DEF
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [KEY_COUNT-1:0] KEY_INPUT_N,
    input wire logic BUTTON_WAKE_PIN,
    input wire logic AUX_HIGH_CMP,
    input wire logic EXT_SUPPLY_LOW_CMP,
    input wire logic EXT_SUPPLY_RECOVERED_CMP,
    input wire logic EXT_SUPPLY_CLK_OK_CMP,
    input wire logic EXT_SUPPLY_GOOD_CMP,
    input wire logic OSC_SETTLED,
    input wire logic STATUS_READ,
    input wire logic CLEAR_IRQ_CMD,
    input wire logic [7:0] STATUS_DATA,
    input wire logic IRQ,
    input wire logic HOST_RESET_N,
    input wire logic EXT_SUPPLY_ENABLE_BIT,
    input wire logic CLK_ON_BIT,
    input wire logic CLK_OUT_EN,
    input wire logic OFF_MODE
);
    localparam int QUIET_LIM = DEBOUNCE_TICKS * DCLK_DIV + 12;
    logic [15:0] quiet_reg, quiet_next;
    logic [6:0] pins_reg, pins_next;
    logic quiet, key_move;
    // ==========
    // idle counter; saturates so it never wraps
    always_comb begin
        pins_next = {KEY_INPUT_N, BUTTON_WAKE_PIN, AUX_HIGH_CMP};
        key_move = pins_next[6:2] != pins_reg[6:2];
        quiet_next = (quiet_reg == 16'hffff) ? quiet_reg : quiet_reg + 16'h0001;
        if (pins_next != pins_reg) begin
            quiet_next = 16'h0000;
        end
        quiet = int'(quiet_reg) >= QUIET_LIM;
    end
    always_ff @(posedge REF_CLK) begin
        quiet_reg <= RST ? 16'h0000 : quiet_next;
        pins_reg <= pins_next;
    end
    // ==========
    // assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    a_reset_quiet: assert property ($fell(RST) |-> STATUS_DATA == STATUS_RESET && !IRQ && !HOST_RESET_N)
        else $error("outputs not cleared by reset");
    a_read_clears: assert property (quiet && STATUS_READ |=> !STATUS_DATA[5] && !STATUS_DATA[7] && !IRQ)
        else $error("read left flag or irq set");
    a_clear_irq: assert property (quiet && CLEAR_IRQ_CMD |=> !IRQ)
        else $error("irq high after clear command");
    a_dbnc_enables: assert property (quiet && key_move && !OFF_MODE |-> ##[2:6] (EXT_SUPPLY_ENABLE_BIT && CLK_ON_BIT))
        else $error("enables not forced in debounce");
    a_wake_enables: assert property (!OFF_MODE && STATUS_DATA[5] && $past(STATUS_DATA[5]) |-> CLK_ON_BIT && EXT_SUPPLY_ENABLE_BIT)
        else $error("enables low with wake flag");
    a_hold_reset: assert property ((!EXT_SUPPLY_GOOD_CMP || !OSC_SETTLED) [*5] |-> !HOST_RESET_N)
        else $error("host reset released early");
    a_clk_gate: assert property ((!EXT_SUPPLY_CLK_OK_CMP || !OSC_SETTLED) [*5] |-> !CLK_OUT_EN)
        else $error("clock output on too soon");
    a_low_set: assert property (EXT_SUPPLY_LOW_CMP [*5] |-> STATUS_DATA[LOW_SUPPLY_BIT])
        else $error("low supply bit not set");
    a_low_keep: assert property (!EXT_SUPPLY_RECOVERED_CMP [*5] ##0 STATUS_DATA[6] |=> STATUS_DATA[6])
        else $error("low supply bit cleared early");
    c_key_done: cover property ($rose(STATUS_DATA[0]));
    c_aux_flag: cover property ($rose(STATUS_DATA[AUX_FLAG_BIT]));
    c_off_exit: cover property ($fell(OFF_MODE));
endmodule
bind wake_status_irq_logic wake_status_sva #(.DEBOUNCE_TICKS(DEBOUNCE_TICKS), .DCLK_DIV(DCLK_DIV)) u_sva (
    .REF_CLK, .RST, .KEY_INPUT_N, .BUTTON_WAKE_PIN, .AUX_HIGH_CMP, .EXT_SUPPLY_LOW_CMP,
    .EXT_SUPPLY_RECOVERED_CMP, .EXT_SUPPLY_CLK_OK_CMP, .EXT_SUPPLY_GOOD_CMP, .OSC_SETTLED,
    .STATUS_READ, .CLEAR_IRQ_CMD, .STATUS_DATA, .IRQ, .HOST_RESET_N, .EXT_SUPPLY_ENABLE_BIT,
    .CLK_ON_BIT, .CLK_OUT_EN, .OFF_MODE);

//--- tb/host_model.sv
// Purpose: host controller model issuing status reads and irq clears
// Assumes: runs on the block clock, as the serial decoder does
// Notes: each request becomes one single-cycle pulse
module host_model import wake_status_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic rd_go,
    input wire logic clr_go,
    input wire logic [7:0] status_data,
    output logic status_read,
    output logic clear_irq_cmd,
    output logic [7:0] rd_data
);
    // ==========
    // one pulse per request; data is the pre-read value
    always_ff @(posedge clk) begin
        status_read <= rd_go && !rst;
        clear_irq_cmd <= clr_go && !rst;
        if (status_read) begin
            rd_data <= status_data;
        end
    end
endmodule

//--- tb/wake_status_irq_logic_tb.sv
// Purpose: self-checking bench for the wake, status and interrupt block
// Assumes: short debounce count
// Notes: reads and clears go through the host model
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module wake_status_irq_logic_tb import wake_status_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICKS = 16;
    logic clk = 1'h0, rst = 1'h1, btn = 1'h0, aux_hi = 1'h0, aux_sup = 1'h0, low = 1'h0;
    logic rec = 1'h1, good = 1'h1, core = 1'h1, osc = 1'h1, off_cmd = 1'h0, rd_go = 1'h0, clr_go = 1'h0;
    logic [4:0] key_n = KEY_IDLE;
    logic st_rd, clr, irq, hrst_n, core_en, ext_en, clk_on, clk_oe, off_mode;
    logic [7:0] sd, rd_data;
    int n_checks = 0;
    int n_mismatch = 0;
    wake_status_irq_logic #(.DEBOUNCE_TICKS(TICKS), .DCLK_DIV(1)) uut (
        .REF_CLK(clk), .RST(rst), .KEY_INPUT_N(key_n), .BUTTON_WAKE_PIN(btn), .AUX_LOW_CMP(aux_hi),
        .AUX_HIGH_CMP(aux_hi), .AUX_ABOVE_SUPPLY_CMP(aux_sup), .EXT_SUPPLY_LOW_CMP(low),
        .EXT_SUPPLY_RECOVERED_CMP(rec), .EXT_SUPPLY_CLK_OK_CMP(1'h1), .EXT_SUPPLY_GOOD_CMP(good),
        .CORE_SUPPLY_UP_CMP(core), .OSC_SETTLED(osc), .STATUS_READ(st_rd), .CLEAR_IRQ_CMD(clr),
        .OFF_CMD(off_cmd), .EXT_SUPPLY_ENABLE_SW(1'h0), .CLK_ON_SW(1'h0), .STATUS_DATA(sd), .IRQ(irq),
        .HOST_RESET_N(hrst_n), .CORE_SUPPLY_EN(core_en), .EXT_SUPPLY_ENABLE_BIT(ext_en),
        .CLK_ON_BIT(clk_on), .CLK_OUT_EN(clk_oe), .OFF_MODE(off_mode));
    host_model host (.clk(clk), .rst(rst), .rd_go(rd_go), .clr_go(clr_go), .status_data(sd),
        .status_read(st_rd), .clear_irq_cmd(clr), .rd_data(rd_data));
    // ==========
    // 100 MHz clock
    always #5 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait for irq
    task automatic wait_irq();
        for (int i = 0; i < 400 && irq !== 1'h1; i++) tick(1);
        `CHK("irq", 1'h1, irq)
    endtask
    task automatic host_read();
        rd_go = 1'h1;
        tick(1);
        rd_go = 1'h0;
        tick(2);
    endtask
    task automatic host_clear();
        clr_go = 1'h1;
        tick(1);
        clr_go = 1'h0;
        tick(2);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_key();
        key_n = 5'h1e;
        tick(5);
        `CHK("ext_en", 1'h1, ext_en)
        `CHK("clk_on", 2'h3, {clk_on, clk_oe})
        wait_irq();
        `CHK("keys", 5'h01, sd[4:0])
        host_read();
        `CHK("rd_data", 8'h01, rd_data)
        `CHK("irq", 1'h0, irq)
        key_n = KEY_IDLE;
        wait_irq();
        `CHK("keys", 5'h00, sd[4:0])
        host_clear();
        `CHK("irq", 1'h0, irq)
    endtask
    task automatic t_abort_restart();
        tick(40);
        key_n = 5'h1d;
        tick(4);
        key_n = KEY_IDLE;
        tick(40);
        `CHK("irq", 1'h0, irq)
        key_n = 5'h17;
        tick(10);
        key_n = 5'h07;
        tick(16);
        `CHK("irq", 1'h0, irq)
        wait_irq();
        `CHK("keys", 5'h18, sd[4:0])
        key_n = KEY_IDLE;
        host_read();
        wait_irq();
        host_read();
    endtask
    task automatic t_button();
        btn = 1'h1;
        wait_irq();
        `CHK("wake", 1'h1, sd[WAKE_FLAG_BIT])
        `CHK("ext_en", 1'h1, ext_en && clk_on)
        tick(30);
        host_clear();
        btn = 1'h0;
        tick(5);
        btn = 1'h1;
        tick(10);
        `CHK("irq", 1'h0, irq)
        host_read();
        `CHK("wake", 2'h2, {rd_data[5], sd[5]})
        btn = 1'h0;
    endtask
    task automatic t_aux();
        aux_hi = 1'h1;
        tick(10);
        `CHK("aux", 1'h0, sd[AUX_FLAG_BIT])
        aux_hi = 1'h0;
        aux_sup = 1'h1;
        tick(5);
        aux_hi = 1'h1;
        wait_irq();
        `CHK("aux", 1'h1, sd[AUX_FLAG_BIT])
        host_read();
        `CHK("aux", 2'h0, {sd[7], irq})
        aux_hi = 1'h0;
    endtask
    task automatic t_low();
        low = 1'h1;
        rec = 1'h0;
        tick(40);
        `CHK("low", 1'h1, sd[LOW_SUPPLY_BIT])
        host_read();
        `CHK("low", 1'h1, sd[LOW_SUPPLY_BIT])
        low = 1'h0;
        rec = 1'h1;
        tick(6);
        host_read();
        `CHK("low", 1'h0, sd[LOW_SUPPLY_BIT])
    endtask
    task automatic t_off_wake();
        off_cmd = 1'h1;
        tick(1);
        off_cmd = 1'h0;
        core = 1'h0;
        osc = 1'h0;
        tick(6);
        `CHK("off", 2'h2, {off_mode, clk_oe})
        key_n = 5'h1b;
        tick(MIN_WAKE_CYCLES + 10);
        `CHK("wake", 3'h5, {core_en, hrst_n, ext_en})
        core = 1'h1;
        osc = 1'h1;
        wait_irq();
        `CHK("keys", 6'h04, {off_mode, sd[4:0]})
        tick(6);
        `CHK("hrst_n", 1'h1, hrst_n)
        key_n = KEY_IDLE;
        host_read();
        off_cmd = 1'h1;
        tick(1);
        off_cmd = 1'h0;
        aux_hi = 1'h1;
        wait_irq();
        `CHK("aux", 2'h2, {sd[7], off_mode})
    endtask
    // ==========
    // main sequence, reset held for 5 cycles
    initial begin
        tick(5);
        rst = 1'h0;
        `CHK("reset", 10'h000, {sd, irq, hrst_n})
        tick(6);
        `CHK("hrst_n", 1'h1, hrst_n)
        t_key();
        t_abort_restart();
        t_button();
        t_aux();
        t_low();
        t_off_wake();
        print_verdict();
    end
    // watchdog, far past the run
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
